// *** core/hsm_pkg.sv ***
// Behaviour
// - Boot loads defaults, then rests low-power
// - Playback start enters drive state
// - Playback end returns to selected rest
// - Any fault after boot forces low-power rest directly
// - Mode field: inactive, reg, pwm, rtm, etm
// - Inactive waits until request and faults clear
// - Registers and serial port survive rest states
// - Waveform memory survives all states
// - Embedded: no fault clear, retry each request
// - Register streaming drives direct drive level
// - Register-triggered memory ignores input edges
// - Edge-triggered memory: configured input edge or bit
// - Output switches at fixed 187.5 kHz
// - Output short puts bridge in high impedance
// - Open loop disables back-EMF adjustment
// - Closed loop enables features individually
// - Open loop allows shaped waveform, sine default
// - Supply limits drive level, reading exported
// - Over-temperature warns and shuts drive down
// - Output within 7.5 us or 1.5 us (750 or 150 cycles)
package hsm_pkg;

   // =========================================================
   // Modes and timing
   // =========================================================
   localparam logic [2:0] MODE_INACTIVE  = 3'h0;
   localparam logic [2:0] MODE_REG_STRM  = 3'h1;
   localparam logic [2:0] MODE_PWM_STRM  = 3'h2;
   localparam logic [2:0] MODE_REG_TRIG  = 3'h3;
   localparam logic [2:0] MODE_EDGE_TRIG = 3'h4;

   localparam int CLK_HZ       = 100_000_000;
   localparam int PWM_HZ_X10   = 1_875_000;
   localparam int PWM_DIV      = (CLK_HZ * 10) / PWM_HZ_X10;
   localparam int WAKE_IDLE_US_X100 = 75;
   localparam int WAKE_STBY_US_X100 = 15;
   localparam int WAKE_IDLE_CYC = (WAKE_IDLE_US_X100 * 1000) / 100;
   localparam int WAKE_STBY_CYC = (WAKE_STBY_US_X100 * 1000) / 100;
   localparam int BOOT_CYC     = 16;

   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;

   typedef enum logic [4:0] {
      HSM_BOOT  = 5'b00001,
      HSM_IDLE  = 5'b00010,
      HSM_STBY  = 5'b00100,
      HSM_WAKE  = 5'b01000,
      HSM_DRIVE = 5'b10000
   } hsm_state_e;

endpackage : hsm_pkg

// *** core/hsm_pwm_gen.sv ***
// =========================================================
// Fixed-rate H-bridge PWM generator
// =========================================================
module hsm_pwm_gen #(
   parameter int DIV = 533
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       en_i,
   input  wire logic [7:0] level_i,
   output logic            pos_o,
   output logic            neg_o
);
   logic [9:0] cnt;
   logic [17:0] thr;
   logic       neg_sign;
   logic [7:0] mag;

   // Signed level gives magnitude and polarity.
   assign neg_sign = level_i[7];
   assign mag      = neg_sign ? 8'(~level_i + 8'h01) : level_i;
   assign thr      = 18'(mag) * 18'(DIV) / 18'h00080;

   // Period counter is independent of any input PWM rate.
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_i || cnt == 10'(DIV - 1)) begin
         cnt <= 10'h000;
      end else begin
         cnt <= cnt + 10'h001;
      end
   end

   // Duty comparison steers one bridge side.
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_i) begin
         pos_o <= 1'b0;
         neg_o <= 1'b0;
      end else begin
         pos_o <= !neg_sign && (18'(cnt) < thr);
         neg_o <= neg_sign && (18'(cnt) < thr);
      end
   end
endmodule : hsm_pwm_gen

// *** core/hsm_ctrl.sv ***
// =========================================================
// State and mode controller
// =========================================================
module hsm_ctrl #(
   parameter int WAKE_IDLE = hsm_pkg::WAKE_IDLE_CYC,
   parameter int WAKE_STBY = hsm_pkg::WAKE_STBY_CYC
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [2:0] mode_i,
   input  wire logic       standby_en_i,
   input  wire logic       sequence_trigger_i,
   input  wire logic [7:0] direct_drive_level_i,
   input  wire logic [7:0] pwm_level_i,
   input  wire logic [7:0] memory_level_i,
   input  wire logic       playback_done_i,
   input  wire logic [2:0] gpi_i,
   input  wire logic [5:0] gpi_edge_cfg_i,
   input  wire logic       closed_loop_i,
   input  wire logic [3:0] loop_feature_en_i,
   input  wire logic       custom_wave_en_i,
   input  wire logic [7:0] supply_level_i,
   input  wire logic       short_fault_i,
   input  wire logic       temp_fault_i,
   input  wire logic       other_fault_i,
   input  wire logic       fault_clear_i,
   input  wire logic       embedded_i,
   output logic [4:0]      state_o,
   output logic            drive_active_o,
   output logic            output_positive_o,
   output logic            output_negative_o,
   output logic            bridge_hiz_o,
   output logic            back_emf_en_o,
   output logic [3:0]      loop_feature_o,
   output logic            shaped_wave_o,
   output logic [7:0]      supply_level_o,
   output logic            temp_warning_o,
   output logic            fault_o,
   output logic            memory_start_o
);
   hsm_pkg::hsm_state_e state;
   hsm_pkg::hsm_state_e next_state;
   logic [2:0]  gpi_m;
   logic [2:0]  gpi_s;
   logic [2:0]  gpi_d;
   logic [2:0]  gpi_hit;
   logic [13:0] wait_cnt;
   logic [4:0]  boot_cnt;
   logic        fault_flag;
   logic        fault_now;
   logic        edge_req;
   logic        request;
   logic        mode_mem;
   logic [7:0]  src_level;
   logic [7:0]  lim_level;
   logic [7:0]  drv_level;
   logic        pwm_pos;
   logic        pwm_neg;

   // Edge detect per input with its configured sense.
   function automatic logic edge_hit(input logic cur, input logic prv,
                                     input logic [1:0] cfg);
      case (cfg)
         hsm_pkg::EDGE_RISE: edge_hit = cur && !prv;
         hsm_pkg::EDGE_FALL: edge_hit = !cur && prv;
         hsm_pkg::EDGE_BOTH: edge_hit = cur != prv;
         default:            edge_hit = 1'b0;
      endcase
   endfunction : edge_hit

   // Pins from outside are synchronised twice.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gpi_m <= 3'h0;
         gpi_s <= 3'h0;
         gpi_d <= 3'h0;
      end else begin
         gpi_m <= gpi_i;
         gpi_s <= gpi_m;
         gpi_d <= gpi_s;
      end
   end

   // Trigger decode per mode.
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_edge
         assign gpi_hit[g] = edge_hit(gpi_s[g], gpi_d[g],
                                      gpi_edge_cfg_i[2*g +: 2]);
      end
   endgenerate
   assign edge_req = (mode_i == hsm_pkg::MODE_EDGE_TRIG) && |gpi_hit;
   assign mode_mem = (mode_i == hsm_pkg::MODE_REG_TRIG) ||
                     (mode_i == hsm_pkg::MODE_EDGE_TRIG);
   // Only the register bit starts register-triggered playback.
   assign request = (mode_mem && sequence_trigger_i) || edge_req ||
                    (mode_i == hsm_pkg::MODE_REG_STRM) ||
                    (mode_i == hsm_pkg::MODE_PWM_STRM);
   assign fault_now = short_fault_i || temp_fault_i || other_fault_i;

   // Sticky fault; embedded use clears it on each request.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_flag <= 1'b0;
      end else if (fault_now) begin
         fault_flag <= 1'b1; // set wins over clear
      end else if (fault_clear_i || (embedded_i && request)) begin
         fault_flag <= 1'b0;
      end
   end

   // Next-state selection.
   always_comb begin
      next_state = state;
      case (state)
         hsm_pkg::HSM_BOOT: begin
            if (boot_cnt == 5'(hsm_pkg::BOOT_CYC)) begin
               next_state = hsm_pkg::HSM_IDLE;
            end
         end
         hsm_pkg::HSM_IDLE, hsm_pkg::HSM_STBY: begin
            if (!standby_en_i) begin
               next_state = hsm_pkg::HSM_IDLE;
            end else begin
               next_state = hsm_pkg::HSM_STBY;
            end
            if (request && (!fault_flag || embedded_i)) begin
               next_state = hsm_pkg::HSM_WAKE;
            end
         end
         hsm_pkg::HSM_WAKE: begin
            if (wait_cnt == 14'h0001) begin
               next_state = hsm_pkg::HSM_DRIVE;
            end
         end
         hsm_pkg::HSM_DRIVE: begin
            if (playback_done_i || mode_i == hsm_pkg::MODE_INACTIVE) begin
               next_state = standby_en_i ? hsm_pkg::HSM_STBY
                                         : hsm_pkg::HSM_IDLE;
            end
         end
         default: next_state = hsm_pkg::HSM_IDLE;
      endcase
      if (fault_now && state != hsm_pkg::HSM_BOOT) begin
         next_state = hsm_pkg::HSM_IDLE;
      end
   end

   // State register and boot timer; no register is cleared on rest.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state    <= hsm_pkg::HSM_BOOT;
         boot_cnt <= 5'h00;
      end else begin
         state <= next_state;
         if (state == hsm_pkg::HSM_BOOT) begin
            boot_cnt <= boot_cnt + 5'h01;
         end
      end
   end

   // Wake latency counter, shorter from standby.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wait_cnt <= 14'h0000;
      end else if (next_state == hsm_pkg::HSM_WAKE &&
                   state != hsm_pkg::HSM_WAKE) begin
         wait_cnt <= (state == hsm_pkg::HSM_STBY) ? 14'(WAKE_STBY)
                                                   : 14'(WAKE_IDLE);
      end else if (wait_cnt != 14'h0000) begin
         wait_cnt <= wait_cnt - 14'h0001;
      end
   end

   // Source select and supply limit.
   assign src_level = (mode_i == hsm_pkg::MODE_REG_STRM) ?
                      direct_drive_level_i :
                      (mode_i == hsm_pkg::MODE_PWM_STRM) ? pwm_level_i
                                                         : memory_level_i;
   assign lim_level = (src_level[7] ? 8'(~src_level + 8'h01) : src_level)
                      > supply_level_i ?
                      (src_level[7] ? 8'(~supply_level_i + 8'h01)
                                    : supply_level_i)
                      : src_level;
   assign drv_level = (state == hsm_pkg::HSM_DRIVE) ? lim_level : 8'h00;

   hsm_pwm_gen #(
      .DIV (hsm_pkg::PWM_DIV)
   ) u_pwm (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .en_i    (state == hsm_pkg::HSM_DRIVE && !fault_now),
      .level_i (drv_level),
      .pos_o   (pwm_pos),
      .neg_o   (pwm_neg)
   );

   // Registered outputs.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_o           <= 5'h01;
         drive_active_o    <= 1'b0;
         output_positive_o <= 1'b0;
         output_negative_o <= 1'b0;
         bridge_hiz_o      <= 1'b1;
         back_emf_en_o     <= 1'b0;
         loop_feature_o    <= 4'h0;
         shaped_wave_o     <= 1'b0;
         supply_level_o    <= 8'h00;
         temp_warning_o    <= 1'b0;
         fault_o           <= 1'b0;
         memory_start_o    <= 1'b0;
      end else begin
         state_o           <= 5'(next_state);
         drive_active_o    <= next_state == hsm_pkg::HSM_DRIVE;
         output_positive_o <= pwm_pos && !short_fault_i;
         output_negative_o <= pwm_neg && !short_fault_i;
         bridge_hiz_o      <= short_fault_i || temp_fault_i ||
                              state != hsm_pkg::HSM_DRIVE;
         back_emf_en_o     <= closed_loop_i;
         loop_feature_o    <= closed_loop_i ? loop_feature_en_i
                                            : 4'h0;
         shaped_wave_o     <= !closed_loop_i && custom_wave_en_i;
         supply_level_o    <= supply_level_i;
         temp_warning_o    <= temp_fault_i;
         fault_o           <= fault_flag || fault_now;
         memory_start_o    <= mode_mem && state == hsm_pkg::HSM_WAKE &&
                              next_state == hsm_pkg::HSM_DRIVE;
      end
   end
endmodule : hsm_ctrl

// *** tb/hsm_ctrl_props.sv ***
// =========================================================
// State controller checker
// =========================================================
module hsm_ctrl_props #(
   parameter int WAKE_IDLE = 750,
   parameter int WAKE_STBY = 150
) (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic [2:0] mode_i,
   input wire logic       standby_en_i,
   input wire logic       playback_done_i,
   input wire logic       closed_loop_i,
   input wire logic [3:0] loop_feature_en_i,
   input wire logic       custom_wave_en_i,
   input wire logic       short_fault_i,
   input wire logic       temp_fault_i,
   input wire logic       other_fault_i,
   input wire logic [4:0] state_o,
   input wire logic       drive_active_o,
   input wire logic       bridge_hiz_o,
   input wire logic       back_emf_en_o,
   input wire logic [3:0] loop_feature_o,
   input wire logic       shaped_wave_o,
   input wire logic       fault_o,
   input wire logic       memory_start_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic live;
   logic from_stby;
   int   wake_cnt;
   logic [4:0] rest;

   // Live fault and the rest state picked by the select bit.
   assign live = short_fault_i | temp_fault_i | other_fault_i;
   assign rest = standby_en_i ? 5'h04 : 5'h02;

   // Counts wake cycles and remembers which rest state came before.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_cnt  <= 0;
         from_stby <= 1'b0;
      end else begin
         wake_cnt <= (state_o == 5'h08) ? wake_cnt + 1 : 0;
         if (state_o == 5'h04 || state_o == 5'h02) begin
            from_stby <= (state_o == 5'h04);
         end
      end
   end

   a_boot_exit: assert property (state_o == 5'h01 ##1 state_o != 5'h01
      |-> state_o == 5'h02) else $error("boot exit wrong");
   a_drive_flag: assert property (drive_active_o == (state_o == 5'h10))
      else $error("drive flag wrong");
   a_play_end: assert property (state_o == 5'h10 && playback_done_i
      && !fault_o && !live |=> state_o == $past(rest))
      else $error("wrong rest after playback");
   a_fault_idle: assert property (live && state_o != 5'h01
      |=> state_o == 5'h02) else $error("fault did not idle");
   a_start_pulse: assert property (memory_start_o
      |-> state_o == 5'h10 && $past(state_o) == 5'h08)
      else $error("memory start misplaced");
   a_short_hiz: assert property (short_fault_i |=> bridge_hiz_o)
      else $error("short left bridge driven");
   a_open_loop: assert property (!closed_loop_i
      |=> !back_emf_en_o && loop_feature_o == 4'h0)
      else $error("open loop not plain");
   a_closed_feat: assert property (closed_loop_i
      |=> back_emf_en_o && loop_feature_o == $past(loop_feature_en_i))
      else $error("loop features wrong");
   a_shaped_wave: assert property (!rst_i |=> shaped_wave_o
      == $past(custom_wave_en_i && !closed_loop_i))
      else $error("shape wrong");
   a_wake_time: assert property (state_o == 5'h08 ##1 state_o == 5'h10
      |-> wake_cnt == (from_stby ? WAKE_STBY : WAKE_IDLE))
      else $error("wake time wrong");
   a_mode_off: assert property (state_o == 5'h10 && mode_i == 3'h0
      && !fault_o && !live |=> state_o == $past(rest))
      else $error("inactive mode kept drive");
endmodule : hsm_ctrl_props

bind hsm_ctrl hsm_ctrl_props #(
   .WAKE_IDLE(WAKE_IDLE),
   .WAKE_STBY(WAKE_STBY)
) u_props (.*);

// *** tb/hsm_host_model.sv ***
// =========================================================
// Playback source model
// =========================================================
module hsm_host_model (
   input  wire logic       clk_i,
   input  wire logic       drive_i,
   input  wire logic [7:0] hold_i,
   output logic            done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt = 8'h00;

   initial done_o = 1'b0;

   // Ends playback hold_i cycles into drive; zero never ends it.
   always @(posedge clk_i) begin
      cnt    <= drive_i ? cnt + 8'h01 : 8'h00;
      done_o <= drive_i && hold_i != 8'h00 && cnt == hold_i;
   end
endmodule : hsm_host_model

// *** tb/hsm_ctrl_tb_top.sv ***
// =========================================================
// State controller bench
// =========================================================
module hsm_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [2:0] mode = 3'h0;
   logic [2:0] gpi = 3'h0;
   logic [7:0] hold = 8'h05;
   logic       sb = 1'b0, trg = 1'b0, cl = 1'b0, sf = 1'b0;
   logic       tf = 1'b0, of = 1'b0, fc = 1'b0, emb = 1'b0;
   logic [4:0] st;
   logic       done, da, hz, tw;
   logic       cw = 1'b1, op, on, fo;
   logic [7:0] ddl = 8'h40, sup = 8'h70, sl;
   logic [5:0] ecfg = 6'h33;
   logic [3:0] lfe = 4'h5;
   int         checks = 0, n_fail = 0, cyc = 0;

   // Short wake counts keep the run brief.
   hsm_ctrl #(.WAKE_IDLE(40), .WAKE_STBY(12)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .standby_en_i(sb),
      .sequence_trigger_i(trg), .direct_drive_level_i(ddl),
      .pwm_level_i(8'h30), .memory_level_i(8'h20),
      .playback_done_i(done), .gpi_i(gpi), .gpi_edge_cfg_i(ecfg),
      .closed_loop_i(cl), .loop_feature_en_i(lfe),
      .custom_wave_en_i(cw), .supply_level_i(sup),
      .short_fault_i(sf), .temp_fault_i(tf), .other_fault_i(of),
      .fault_clear_i(fc), .embedded_i(emb), .state_o(st),
      .drive_active_o(da), .output_positive_o(op),
      .output_negative_o(on), .bridge_hiz_o(hz), .back_emf_en_o(),
      .loop_feature_o(), .shaped_wave_o(), .supply_level_o(sl),
      .temp_warning_o(tw), .fault_o(fo), .memory_start_o());

   hsm_host_model host (.clk_i(clk_i), .drive_i(da), .hold_i(hold),
      .done_o(done));

   // Clock, and a cycle limit that cuts a hang short.
   initial forever #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task step; @(posedge clk_i); #1; endtask : step
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wt(input logic [4:0] s);
      for (int i = 0; i < 400 && st !== s; i++) step();
      chk({3'h0, st}, {3'h0, s});
   endtask : wt
   // Picks the bridge side that a measurement watches.
   function automatic logic sig(input logic neg);
      return neg ? on : op;
   endfunction : sig
   // Counts one whole bridge period, starting at a full pulse.
   task meas(input logic neg, output int hi, output int per);
      hi = 0;
      per = 0;
      while (sig(neg) !== 1'b1) step();
      while (sig(neg) !== 1'b0) step();
      while (sig(neg) !== 1'b1) step();
      while (sig(neg) === 1'b1) begin
         hi++;
         per++;
         step();
      end
      while (sig(neg) === 1'b0) begin
         per++;
         step();
      end
   endtask : meas
   task pulse_trg; @(posedge clk_i) trg <= 1'b1;
      @(posedge clk_i) trg <= 1'b0; endtask : pulse_trg
   task tally_and_finish;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   // Boot ends in the low-power rest state.
   task t_boot; step(); chk({3'h0, st}, 8'h01);
      wt(5'h02); endtask : t_boot
   // Register trigger mode ignores pins, starts on the bit.
   task t_reg_trig;
      @(posedge clk_i) begin mode <= 3'h3; sb <= 1'b1; gpi[1] <= 1'b1; end
      repeat (10) step(); chk(da, 1'b0);
      pulse_trg(); wt(5'h10);
      wt(5'h04); endtask : t_reg_trig
   // Edge mode starts on the configured edge: rising, then falling, then both.
   task t_edge_trig;
      @(posedge clk_i) begin mode <= 3'h4; gpi[1] <= 1'b0; end
      repeat (10) step(); chk({3'h0, st}, 8'h04);
      @(posedge clk_i) gpi[1] <= 1'b1;
      wt(5'h10);
      wt(5'h04);
      @(posedge clk_i) begin ecfg <= 6'h37; gpi[1] <= 1'b0; end
      wt(5'h10);
      wt(5'h04);
      @(posedge clk_i) begin ecfg <= 6'h3B; gpi[1] <= 1'b1; end
      wt(5'h10);
      wt(5'h04);
   endtask : t_edge_trig
   // Faults force idle and block requests until cleared.
   task t_fault;
      @(posedge clk_i) hold <= 8'h00;
      pulse_trg(); wt(5'h10);
      @(posedge clk_i) sf <= 1'b1; step(); chk({3'h0, st}, 8'h02);
      chk(hz, 1'b1);
      chk(fo, 1'b1);
      @(posedge clk_i) begin sf <= 1'b0; tf <= 1'b1; end
      step(); chk(tw, 1'b1);
      @(posedge clk_i) tf <= 1'b0; pulse_trg(); repeat (5) step();
      chk({3'h0, st}, 8'h04);
      @(posedge clk_i) fc <= 1'b1; @(posedge clk_i) fc <= 1'b0;
      pulse_trg(); wt(5'h10);
      @(posedge clk_i) mode <= 3'h0; wt(5'h04);
      @(posedge clk_i) begin emb <= 1'b1; mode <= 3'h4; of <= 1'b1; end
      @(posedge clk_i) begin of <= 1'b0; hold <= 8'h05; end
      pulse_trg(); wt(5'h10); wt(5'h04); endtask : t_fault
   // Streaming modes hold drive until the mode goes inactive.
   task t_stream;
      @(posedge clk_i) begin
         mode <= 3'h1;
         cl   <= 1'b1;
         hold <= 8'h00;
         lfe  <= 4'hA;
      end
      wt(5'h10);
      @(posedge clk_i) mode <= 3'h2; repeat (3) step(); chk(da, 1'b1);
      @(posedge clk_i) begin mode <= 3'h0; cl <= 1'b0; end
      wt(5'h04); endtask : t_stream
   // Bridge rate is fixed; the drive level is clipped to the supply.
   task t_pwm;
      int hi_a, hi_b, per;
      @(posedge clk_i) begin
         mode <= 3'h1;
         ddl  <= 8'h7F;
         sup  <= 8'h20;
         cw   <= 1'b0;
      end
      wt(5'h10);
      meas(1'b0, hi_a, per);
      chk(16'(per), 16'(hsm_pkg::PWM_DIV));
      chk(sl, 8'h20);
      @(posedge clk_i) begin
         ddl <= 8'h20;
         sup <= 8'h70;
      end
      meas(1'b0, hi_b, per);
      chk(16'(hi_a), 16'(hi_b));
      @(posedge clk_i) begin
         ddl <= 8'h81;
         sup <= 8'h20;
      end
      meas(1'b1, hi_a, per);
      chk(16'(hi_a), 16'(hi_b));
      chk(op, 1'b0);
      @(posedge clk_i) mode <= 3'h0;
      wt(5'h04);
   endtask : t_pwm

   // Reset, then every scenario in turn.
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_boot();
      t_reg_trig();
      t_edge_trig();
      t_fault();
      t_stream();
      t_pwm();
      tally_and_finish();
   end
endmodule : hsm_ctrl_tb_top
